/* File: verification/flash_status_and_protection_test.sv */
// Self-checking bench for the flash status block
module flash_status_and_protection_test
	import fsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end
	localparam int TMO = 20;
	logic ref_clk, reset_n, rd_stb, rd_foreign, rd_at_prog_addr, p;
	logic temp_unprot, op_fail, ready_busy, node;
	logic [6:0] c;
	logic [2:0] rd_blk, prog_blk, erase_blk;
	logic [15:0] array_data, prog_data, prog_old, lock_wdata, d;
	logic [15:0] rd_data, lock_setting_word, pend;
	logic [31:0] q[$];
	logic [31:0] e;
	int fails, n_compared, seed;

	fsp_cpu cpu (.ref_clk, .rd_stb, .rd_blk, .rd_foreign);
	fsp_status #(.TMO_CYC(TMO), .PROT_CYC(TMO)) uut (.ref_clk, .reset_n,
		.rd_stb, .rd_blk, .rd_at_prog_addr, .rd_foreign, .array_data,
		.prog_req(c[0]), .prog_blk, .prog_data, .prog_old,
		.erase_req(c[1]), .erase_blk, .suspend_cmd(c[2]),
		.resume_cmd(c[3]), .read_reset_cmd(c[4]), .temp_unprot,
		.lock_wr(c[5]), .lock_wdata, .op_done(c[6]), .op_fail, .rd_data,
		.ready_busy, .extension_peripheral_node_two(node),
		.lock_setting_word, .lock_pending(pend));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic pulse(input int i);
		c[i] <= 1'b1;
		@(posedge ref_clk);
		c <= 7'h00;
		// Second edge lets the result settle and keeps c to one write a step
		@(posedge ref_clk);
	endtask
	task automatic rst();
		reset_n <= 1'b0;
		tick(10);
		reset_n <= 1'b1;
		tick(2);
	endtask
	task automatic rd(input logic [2:0] b, input logic f, input int n,
		input logic [15:0] m, input logic [15:0] x);
		repeat (n) q.push_back({m, x & m});
		cpu.rd(b, f, n);
		tick(1);
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Result watcher
	// ------------------------------------------------------------
	always @(posedge ref_clk) p <= rd_stb;
	always @(negedge ref_clk) begin
		if (p) begin
			e = q.pop_front();
			`CHK(rd_data & e[31:16], e[15:0])
		end
	end

	initial begin
		tick(20000);
		fails++;
		summarize();
	end

	initial begin
		seed = 91959;
		{reset_n, op_fail, temp_unprot, c, prog_blk, erase_blk} = '0;
		{array_data, prog_data, lock_wdata} = '0;
		prog_old = 16'hFFFF;
		rd_at_prog_addr = 1'b1;
		rst();
		lock_wdata <= 16'hFFFF;
		pulse(5);
		rst();
		`CHK(lock_setting_word, 16'hFFFF)
		repeat (4) begin
			d = 16'($random(seed));
			array_data <= d;
			rd(3'h5, 1'b1, 1, 16'hFFFF, d);
		end
		d = 16'($random(seed)) | 16'h0080;
		prog_data <= d;
		array_data <= d;
		pulse(0);
		`CHK(ready_busy, 1'b1)
		`CHK(node, 1'b1)
		rd(3'h0, 1'b0, 2, 16'hFFB3, 16'h0000);
		prog_data <= ~d;
		pulse(0);
		pulse(6);
		tick(1);
		`CHK(ready_busy, 1'b0)
		`CHK(node, 1'b0)
		rd(3'h0, 1'b0, 1, 16'hFFFF, d);
		erase_blk <= 3'h2;
		pulse(1);
		`CHK(ready_busy, 1'b1)
		rd(3'h2, 1'b0, 1, 16'hFF9B, 16'h0000);
		tick(TMO + 2);
		rd(3'h2, 1'b0, 2, 16'hFF9B, 16'h0008);
		pulse(2);
		tick(2);
		`CHK(ready_busy, 1'b0)
		rd(3'h4, 1'b0, 1, 16'hFFFF, d);
		rd(3'h2, 1'b0, 1, 16'h00C0, 16'h00C0);
		pulse(3);
		tick(1);
		`CHK(ready_busy, 1'b1)
		op_fail <= 1'b1;
		pulse(6);
		op_fail <= 1'b0;
		tick(1);
		`CHK(ready_busy, 1'b0)
		rd(3'h2, 1'b0, 1, 16'h0020, 16'h0020);
		pulse(4);
		tick(1);
		rd(3'h2, 1'b0, 1, 16'hFFFF, d);
		lock_wdata <= 16'h7FFD;
		pulse(5);
		tick(1);
		`CHK(lock_setting_word, 16'hFFFF)
		`CHK(pend, 16'h7FFD)
		rst();
		`CHK(lock_setting_word, 16'h7FFD)
		rd(3'h0, 1'b1, 1, 16'hFFFF, FSP_LOCKED_READ);
		temp_unprot <= 1'b1;
		prog_blk <= 3'h1;
		pulse(0);
		tick(1);
		`CHK(ready_busy, 1'b1)
		pulse(6);
		tick(2);
		// Locked block without unprotection, then a zero-to-one attempt
		temp_unprot <= 1'b0;
		pulse(0);
		`CHK(ready_busy, 1'b0)
		rd(3'h1, 1'b0, 1, 16'h0020, 16'h0020);
		pulse(4);
		prog_old <= 16'h0000;
		prog_data <= ~d | 16'h0001;
		prog_blk <= 3'h0;
		pulse(0);
		`CHK(ready_busy, 1'b0)
		rd(3'h0, 1'b0, 1, 16'h0020, 16'h0020);
		pulse(4);
		// Erase of a locked block holds polling low, then array data
		prog_old <= 16'hFFFF;
		erase_blk <= 3'h1;
		pulse(1);
		rd(3'h1, 1'b0, 1, 16'h0088, 16'h0008);
		tick(TMO);
		rd(3'h1, 1'b0, 1, 16'hFFFF, d);
		// Program in another block while an erase is suspended
		erase_blk <= 3'h3;
		pulse(1);
		pulse(2);
		`CHK(ready_busy, 1'b0)
		prog_blk <= 3'h4;
		pulse(0);
		`CHK(ready_busy, 1'b1)
		rd(3'h4, 1'b0, 1, 16'h0084, 16'h0084);
		pulse(6);
		`CHK(ready_busy, 1'b0)
		pulse(4);
		tick(2);
		summarize();
	end
endmodule

/* File: verification/fsp_cpu.sv */
// CPU read side model issuing flash read cycles
module fsp_cpu (
	input wire logic ref_clk,
	output logic rd_stb,
	output logic [2:0] rd_blk,
	output logic rd_foreign
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		rd_stb = 1'b0;
		rd_blk = 3'h0;
		rd_foreign = 1'b0;
	end
	// Strobe held for n edges; caller leaves an edge between calls
	task automatic rd(input logic [2:0] b, input logic f, input int n);
		rd_stb <= 1'b1;
		rd_blk <= b;
		rd_foreign <= f;
		repeat (n) @(posedge ref_clk);
		rd_stb <= 1'b0;
	endtask
endmodule

/* File: verification/fsp_status_assertions.sv */
// Port-level checker for the flash status block
module fsp_status_chk
	import fsp_pkg::*;
#(
	parameter int TMO_CYC = FSP_TMO_CYC,
	parameter int PROT_CYC = FSP_PROT_CYC
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic rd_stb,
	input wire logic rd_foreign,
	input wire logic prog_req,
	input wire logic [2:0] prog_blk,
	input wire logic [15:0] prog_data,
	input wire logic [15:0] prog_old,
	input wire logic op_done,
	input wire logic lock_wr,
	input wire logic [15:0] rd_data,
	input wire logic ready_busy,
	input wire logic extension_peripheral_node_two,
	input wire logic [15:0] lock_setting_word
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	busy_start_a: assert property (
		prog_req && !ready_busy && lock_setting_word[prog_blk]
		&& !(|(prog_data & ~prog_old)) |=> ready_busy)
		else $error("accepted program left busy low");
	done_ready_a: assert property (
		op_done && ready_busy |=> !ready_busy)
		else $error("busy stayed high after completion");
	node_rise_a: assert property (
		$rose(ready_busy) |-> ##[0:1] extension_peripheral_node_two)
		else $error("interrupt node missed busy");
	node_fall_a: assert property (
		$fell(ready_busy) |-> ##[0:1] !extension_peripheral_node_two)
		else $error("interrupt node missed ready");
	rd_hold_a: assert property (
		!rd_stb |=> $stable(rd_data))
		else $error("read answer changed without a read");
	stat_resv_a: assert property (
		rd_stb && ready_busy |=> (rd_data & 16'hFF13) == 16'h0000)
		else $error("reserved status bits not zero");
	tog_flip_a: assert property (
		rd_stb && ready_busy ##1 rd_stb && ready_busy
		|=> rd_data[FSP_BIT_TOG1] != $past(rd_data[FSP_BIT_TOG1]))
		else $error("toggle bit did not invert");
	code_lock_a: assert property (
		rd_stb && rd_foreign && !lock_setting_word[FSP_BIT_CODE_LOCK]
		&& !ready_busy |=> rd_data == FSP_LOCKED_READ)
		else $error("locked foreign read leaked data");
	lock_hold_a: assert property (
		lock_wr |=> $stable(lock_setting_word))
		else $error("lock word changed before reset");
endmodule

bind fsp_status fsp_status_chk #(.TMO_CYC(TMO_CYC), .PROT_CYC(PROT_CYC))
	chk (
	.ref_clk(ref_clk),
	.reset_n(reset_n),
	.rd_stb(rd_stb),
	.rd_foreign(rd_foreign),
	.prog_req(prog_req),
	.prog_blk(prog_blk),
	.prog_data(prog_data),
	.prog_old(prog_old),
	.op_done(op_done),
	.lock_wr(lock_wr),
	.rd_data(rd_data),
	.ready_busy(ready_busy),
	.extension_peripheral_node_two(extension_peripheral_node_two),
	.lock_setting_word(lock_setting_word)
	);

/* File: verilog/fsp_pkg.sv */
// Constants for the flash status and protection block
package fsp_pkg;
	localparam int FSP_DW = 16;
	// Status word bit positions
	localparam int FSP_BIT_POLL = 7;
	localparam int FSP_BIT_TOG1 = 6;
	localparam int FSP_BIT_ERR = 5;
	localparam int FSP_BIT_TMO = 3;
	localparam int FSP_BIT_TOG2 = 2;
	// Lock setting word layout
	localparam int FSP_NBLK = 7;
	localparam int FSP_BIT_CODE_LOCK = 15;
	localparam logic [15:0] FSP_LOCK_RST = 16'hFFFF;
	localparam logic [15:0] FSP_LOCKED_READ = 16'h009B;
	// Timing at 40 MHz
	localparam int FSP_CLK_MHZ = 40;
	localparam int FSP_TMO_US = 96;
	localparam int FSP_TMO_CYC = FSP_TMO_US * FSP_CLK_MHZ;
	localparam int FSP_PROT_US = 100;
	localparam int FSP_PROT_CYC = FSP_PROT_US * FSP_CLK_MHZ;
	localparam int FSP_CW = 13;
	typedef enum logic [5:0] {
		FSP_IDLE = 6'h01,
		FSP_PROG = 6'h02,
		FSP_WAIT = 6'h04,
		FSP_ERASE = 6'h08,
		FSP_SUSP = 6'h10,
		FSP_PROTW = 6'h20
	} fsp_state_t;
endpackage

/* File: verilog/fsp_status.sv */
// Flash status word, ready/busy line and protection word logic
module fsp_status
	import fsp_pkg::*;
#(
	parameter int TMO_CYC = FSP_TMO_CYC,
	parameter int PROT_CYC = FSP_PROT_CYC
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic rd_stb,
	input wire logic [2:0] rd_blk,
	input wire logic rd_at_prog_addr,
	input wire logic rd_foreign,
	input wire logic [15:0] array_data,
	input wire logic prog_req,
	input wire logic [2:0] prog_blk,
	input wire logic [15:0] prog_data,
	input wire logic [15:0] prog_old,
	input wire logic erase_req,
	input wire logic [2:0] erase_blk,
	input wire logic suspend_cmd,
	input wire logic resume_cmd,
	input wire logic read_reset_cmd,
	input wire logic temp_unprot,
	input wire logic lock_wr,
	input wire logic [15:0] lock_wdata,
	input wire logic op_done,
	input wire logic op_fail,
	output logic [15:0] rd_data,
	output logic ready_busy,
	output logic extension_peripheral_node_two,
	output logic [15:0] lock_setting_word,
	output logic [15:0] lock_pending
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic blk_locked(input logic [15:0] lw,
		input logic [2:0] b, input logic un);
		blk_locked = !un && (b < 3'(FSP_NBLK)) && !lw[b];
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	fsp_state_t state_r, state_nxt;
	logic [FSP_CW-1:0] cnt_r, cnt_nxt;
	logic [15:0] prog_data_r, prog_data_nxt;
	logic [2:0] erase_blk_r, erase_blk_nxt;
	logic prog_in_susp_r, prog_in_susp_nxt;
	logic tog1_r, tog1_nxt;
	logic tog2_r, tog2_nxt;
	logic err_r, err_nxt;
	logic err_erase_r, err_erase_nxt;
	logic last_erase_r, last_erase_nxt;
	logic [15:0] lock_r, lock_nxt;
	// Erased non-volatile cells hold ones until the one-way lock write
	logic [15:0] pend_r = FSP_LOCK_RST;
	logic [15:0] pend_nxt;
	logic [15:0] rd_data_nxt;
	logic rb_nxt;
	logic strap_r;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		prog_data_nxt = prog_data_r;
		erase_blk_nxt = erase_blk_r;
		prog_in_susp_nxt = prog_in_susp_r;
		tog1_nxt = tog1_r;
		tog2_nxt = tog2_r;
		err_nxt = err_r;
		err_erase_nxt = err_erase_r;
		last_erase_nxt = last_erase_r;
		lock_nxt = lock_r;
		pend_nxt = pend_r;
		rd_data_nxt = array_data;
		// Lock change only ever clears bits
		// one-way lock
		if (lock_wr) begin
			pend_nxt = pend_r & lock_wdata;
		end
		if (strap_r) begin
			lock_nxt = pend_r;
		end
		if (read_reset_cmd) begin
			err_nxt = 1'b0;
			err_erase_nxt = 1'b0;
		end
		unique case (state_r)
		FSP_IDLE, FSP_SUSP: begin
			if (prog_req && !(state_r == FSP_SUSP
				&& prog_blk == erase_blk_r)) begin
				prog_data_nxt = prog_data;
				prog_in_susp_nxt = (state_r == FSP_SUSP);
				last_erase_nxt = 1'b0;
				if ((~prog_old & prog_data) != 16'h0000) begin
					err_nxt = 1'b1;
				end else if (blk_locked(lock_r, prog_blk, temp_unprot)) begin
					err_nxt = 1'b1;
				end else begin
					state_nxt = FSP_PROG;
				end
			end else if (state_r == FSP_SUSP && prog_req) begin
				tog2_nxt = ~tog2_r;
			end else if (erase_req && state_r == FSP_IDLE) begin
				erase_blk_nxt = erase_blk;
				last_erase_nxt = 1'b1;
				cnt_nxt = '0;
				if (blk_locked(lock_r, erase_blk, temp_unprot)) begin
					state_nxt = FSP_PROTW;
				end else begin
					state_nxt = FSP_WAIT;
				end
			end else if (resume_cmd && state_r == FSP_SUSP) begin
				tog1_nxt = ~tog1_r;
				state_nxt = FSP_ERASE;
			end else if (read_reset_cmd && state_r == FSP_SUSP) begin
				state_nxt = FSP_IDLE;
			end
		end
		FSP_WAIT: begin
			if (erase_req) begin
				cnt_nxt = '0;
			end else if (suspend_cmd) begin
				tog1_nxt = ~tog1_r;
				state_nxt = FSP_SUSP;
			end else if (cnt_r == FSP_CW'(TMO_CYC - 1)) begin
				state_nxt = FSP_ERASE;
			end else begin
				cnt_nxt = cnt_r + 1'b1;
			end
		end
		FSP_PROTW: begin
			if (cnt_r == FSP_CW'(PROT_CYC - 1)) begin
				state_nxt = FSP_IDLE;
			end else begin
				cnt_nxt = cnt_r + 1'b1;
			end
		end
		FSP_PROG: begin
			if (op_done) begin
				if (op_fail) begin
					err_nxt = 1'b1;
				end
				state_nxt = prog_in_susp_r ? FSP_SUSP : FSP_IDLE;
			end
		end
		FSP_ERASE: begin
			if (suspend_cmd) begin
				tog1_nxt = ~tog1_r;
				state_nxt = FSP_SUSP;
			end else if (op_done) begin
				// Success leaves the flag as it was; only read/reset or reset_n clears it
				if (op_fail) begin
					err_nxt = 1'b1;
					err_erase_nxt = 1'b1;
				end
				state_nxt = FSP_IDLE;
			end
		end
		default: state_nxt = FSP_IDLE;
		endcase
		// ------------------------------------------------------------
		// Read data path
		// ------------------------------------------------------------
		if (rd_stb) begin
			rd_data_nxt = 16'h0000;
			unique case (state_r)
			FSP_PROG: begin
				rd_data_nxt[FSP_BIT_POLL] = ~prog_data_r[7];
				rd_data_nxt[FSP_BIT_TOG1] = tog1_r;
				tog1_nxt = ~tog1_r;
				rd_data_nxt[FSP_BIT_ERR] = 1'b0;
				rd_data_nxt[FSP_BIT_TMO] = 1'b1;
				rd_data_nxt[FSP_BIT_TOG2] = prog_in_susp_r ?
					(rd_at_prog_addr | tog2_r) : tog2_r;
				if (!prog_in_susp_r) begin
					tog2_nxt = ~tog2_r;
				end
			end
			FSP_WAIT, FSP_ERASE: begin
				rd_data_nxt[FSP_BIT_POLL] = 1'b0;
				rd_data_nxt[FSP_BIT_TOG1] = tog1_r;
				tog1_nxt = ~tog1_r;
				rd_data_nxt[FSP_BIT_TMO] = (state_r == FSP_ERASE);
				rd_data_nxt[FSP_BIT_TOG2] = tog2_r;
				tog2_nxt = ~tog2_r;
			end
			FSP_PROTW: begin
				rd_data_nxt[FSP_BIT_POLL] = 1'b0;
				rd_data_nxt[FSP_BIT_TMO] = 1'b1;
			end
			FSP_SUSP: begin
				if (rd_blk == erase_blk_r) begin
					rd_data_nxt[FSP_BIT_POLL] = 1'b1;
					rd_data_nxt[FSP_BIT_TOG1] = 1'b1;
					rd_data_nxt[FSP_BIT_TMO] = 1'b1;
					rd_data_nxt[FSP_BIT_TOG2] = tog2_r;
					tog2_nxt = ~tog2_r;
				end else begin
					rd_data_nxt = array_data;
				end
			end
			default: begin
				if (err_erase_r && rd_blk == erase_blk_r) begin
					rd_data_nxt[FSP_BIT_ERR] = 1'b1;
					rd_data_nxt[FSP_BIT_TMO] = 1'b1;
					rd_data_nxt[FSP_BIT_TOG2] = tog2_r;
					tog2_nxt = ~tog2_r;
				end else if (err_r) begin
					rd_data_nxt[FSP_BIT_ERR] = 1'b1;
					rd_data_nxt[FSP_BIT_POLL] = last_erase_r | prog_data_r[7];
				end else if (rd_foreign && !lock_r[FSP_BIT_CODE_LOCK]) begin
					rd_data_nxt = FSP_LOCKED_READ;
				end else begin
					rd_data_nxt = array_data;
				end
			end
			endcase
		end else begin
			rd_data_nxt = rd_data;
		end
		rb_nxt = (state_nxt == FSP_PROG) || (state_nxt == FSP_ERASE)
			|| (state_nxt == FSP_WAIT);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= FSP_IDLE;
			cnt_r <= '0;
			prog_data_r <= 16'h0000;
			erase_blk_r <= 3'h0;
			prog_in_susp_r <= 1'b0;
			tog1_r <= 1'b0;
			tog2_r <= 1'b0;
			err_r <= 1'b0;
			err_erase_r <= 1'b0;
			last_erase_r <= 1'b0;
			lock_r <= FSP_LOCK_RST;
			rd_data <= 16'h0000;
			ready_busy <= 1'b0;
			extension_peripheral_node_two <= 1'b0;
			strap_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			prog_data_r <= prog_data_nxt;
			erase_blk_r <= erase_blk_nxt;
			prog_in_susp_r <= prog_in_susp_nxt;
			tog1_r <= tog1_nxt;
			tog2_r <= tog2_nxt;
			err_r <= err_nxt;
			err_erase_r <= err_erase_nxt;
			last_erase_r <= last_erase_nxt;
			lock_r <= lock_nxt;
			rd_data <= rd_data_nxt;
			ready_busy <= rb_nxt;
			extension_peripheral_node_two <= rb_nxt;
			strap_r <= 1'b0;
		end
	end

	// Non-volatile copy: survives reset, so it has no reset branch
	always_ff @(posedge ref_clk) begin
		pend_r <= pend_nxt;
	end

	assign lock_setting_word = lock_r;
	assign lock_pending = pend_r;
endmodule
